/* File: pkg/liu_alarm_pkg.sv */
// Constants for the per-channel alarm, interrupt and error insertion block.
// Assumes a single 20 MHz clock and registers reached over Avalon-MM.
// Operation
// R1: A rising change of the bipolar-violation control puts one bipolar violation into the running test pattern.
// R2: A rising change of the bit-error control inverts one bit of the running test pattern.
// R3: Both insertion controls are sampled on rising edges of the transmit line clock, where their rises are found.
// R4: Software writes an insertion control to zero before writing it to one for each further error.
// R5: The lowest bit of the code and insertion register is unused, reads zero and steers nothing.
// R6: The enable register holds eight masks, top down: equalizer, driver, FIFO limit, code violation, loop code,
//     all ones, signal loss and random pattern detect.
// R7: An enable bit at zero masks its source from the interrupt, at one lets it through, and resets to zero.
// R8: The interrupt pin rises only when the global enable and the source enable are both one.
// R9: Alarm status bits follow their conditions whatever the masks hold.
// R10: The top status bit reads one while the equalizer attenuation flag is set, read-only, reset zero.
// R11: The driver status bit reads one while the transmit driver fails, read-only, reset zero.
// R12: The FIFO limit status bit reads one while the FIFO pointers are within three places of each other.
// R13: Each alarm has a change bit that sets on any change, raises the interrupt if enabled and clears on read.
// R14: Fourteen channels each carry their own registers and work independently.
// R15: An insertion request touches the line only while a test pattern runs and is otherwise dropped.
`default_nettype none

package liu_alarm_pkg;

	localparam int NUM_CH = 14;
	localparam int FIFO_PTR_W = 6;
	localparam logic [FIFO_PTR_W-1:0] FIFO_NEAR_LIMIT = 6'h03;

	// Register indices, byte address is four times the index
	localparam logic [3:0] REG_CODE_INSERT = 4'h3;
	localparam logic [3:0] REG_ALARM_MASK = 4'h4;
	localparam logic [3:0] REG_ALARM_STATUS = 4'h5;
	localparam logic [3:0] REG_ALARM_CHANGE = 4'h6;
	localparam logic [7:0] REG_GLOBAL = 8'hE0;

	// Field positions
	localparam int BIT_INSERT_BPV = 2;
	localparam int BIT_INSERT_BER = 1;
	localparam int BIT_GLOBAL_IRQ_EN = 0;
	localparam int ALARM_EQUALIZER = 7;
	localparam int ALARM_DRIVER = 6;
	localparam int ALARM_FIFO_LIMIT = 5;
	localparam int ALARM_CODE_VIOL = 4;
	localparam int ALARM_LOOP_CODE = 3;
	localparam int ALARM_ALL_ONES = 2;
	localparam int ALARM_SIGNAL_LOSS = 1;
	localparam int ALARM_RANDOM_DET = 0;

	// Values after reset and masks
	localparam logic [7:0] CODE_RESET = 8'h00;
	localparam logic [7:0] CODE_WRITE_MASK = 8'hFE;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] CHANGE_RESET = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// Bus handshake states
	typedef enum logic [0:0] {
		BUS_IDLE   = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_e;

endpackage : liu_alarm_pkg

`default_nettype wire

/* File: src/liu_error_insert.sv */
// One channel's test error inserter on the transmit pattern path.
// Assumes transmit_line_clock is a level synchronous to clock.
`default_nettype none

module liu_error_insert
	import liu_alarm_pkg::*;
(
	input  wire logic clock,
	input  wire logic arst_n,
	input  wire logic transmit_line_clock,
	input  wire logic pattern_active,
	input  wire logic insert_bipolar_violation,
	input  wire logic insert_single_bit_error,
	input  wire logic pattern_bit,
	output logic      line_bit,
	output logic      bipolar_violation
);

	logic transmit_line_clock_prev_reg, transmit_line_clock_prev_next;
	logic bpv_seen_reg, bpv_seen_next;
	logic ber_seen_reg, ber_seen_next;
	logic line_reg, line_next;
	logic viol_reg, viol_next;
	logic tx_edge;

	// Next bit and sampled controls, updated only on transmit clock rises
	always_comb begin
		tx_edge = transmit_line_clock & ~transmit_line_clock_prev_reg;
		transmit_line_clock_prev_next = transmit_line_clock;
		bpv_seen_next = bpv_seen_reg;
		ber_seen_next = ber_seen_reg;
		line_next = line_reg;
		viol_next = viol_reg;
		if (tx_edge) begin
			bpv_seen_next = insert_bipolar_violation; // R3
			ber_seen_next = insert_single_bit_error; // R3
			line_next = pattern_bit ^ (insert_single_bit_error & ~ber_seen_reg & pattern_active); // R2 R15
			viol_next = insert_bipolar_violation & ~bpv_seen_reg & pattern_active; // R1 R15
		end
	end

	// Registers of the inserter
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			transmit_line_clock_prev_reg <= 1'b0;
			bpv_seen_reg <= 1'b0;
			ber_seen_reg <= 1'b0;
			line_reg <= 1'b0;
			viol_reg <= 1'b0;
		end else begin
			transmit_line_clock_prev_reg <= transmit_line_clock_prev_next;
			bpv_seen_reg <= bpv_seen_next;
			ber_seen_reg <= ber_seen_next;
			line_reg <= line_next;
			viol_reg <= viol_next;
		end
	end

	assign line_bit = line_reg;
	assign bipolar_violation = viol_reg;

endmodule : liu_error_insert

`default_nettype wire

/* File: src/liu_alarm_irq.sv */
// Fourteen-channel alarm reporting, interrupt gating and test error insertion.
// Assumes an Avalon-MM master with waitrequest and alarm inputs synchronous to clock.
//
// Decided for this implementation: the Avalon-MM slave port.
`default_nettype none

module liu_alarm_irq
	import liu_alarm_pkg::*;
(
	input  wire logic                         clock,
	input  wire logic                         arst_n,
	input  wire logic [9:0]                   address,
	input  wire logic                         read,
	input  wire logic                         write,
	input  wire logic [31:0]                  writedata,
	input  wire logic [3:0]                   byteenable,
	output logic      [31:0]                  readdata,
	output logic                              waitrequest,
	output logic                              irq,
	input  wire logic [NUM_CH-1:0]            transmit_line_clock,
	input  wire logic [NUM_CH-1:0]            pattern_active,
	input  wire logic [NUM_CH-1:0]            tx_pattern_bit,
	output logic      [NUM_CH-1:0]            tx_line_bit,
	output logic      [NUM_CH-1:0]            tx_bipolar_violation,
	input  wire logic [NUM_CH-1:0]            equalizer_attenuation_flag,
	input  wire logic [NUM_CH-1:0]            driver_failure_flag,
	input  wire logic [NUM_CH-1:0]            code_violation_flag,
	input  wire logic [NUM_CH-1:0]            loop_code_detected,
	input  wire logic [NUM_CH-1:0]            all_ones_detected,
	input  wire logic [NUM_CH-1:0]            receive_signal_lost,
	input  wire logic [NUM_CH-1:0]            random_pattern_detected,
	input  wire logic [NUM_CH*FIFO_PTR_W-1:0] fifo_read_ptr,
	input  wire logic [NUM_CH*FIFO_PTR_W-1:0] fifo_write_ptr
);

	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	// True when a register index selects the given register of the given channel
	function automatic logic chan_hit(
		input logic [7:0] index,
		input int         ch,
		input logic [3:0] reg_sel
	);
		logic [3:0] ch_code;
		ch_code = 4'(ch);
		return (index[7:4] == ch_code) && (index[3:0] == reg_sel);
	endfunction : chan_hit

	// True when two FIFO pointers stand within the limit of each other
	function automatic logic fifo_near(
		input logic [FIFO_PTR_W-1:0] rd_ptr,
		input logic [FIFO_PTR_W-1:0] wr_ptr
	);
		logic [FIFO_PTR_W-1:0] ahead;
		logic [FIFO_PTR_W-1:0] behind;
		ahead = wr_ptr - rd_ptr;
		behind = rd_ptr - wr_ptr;
		return (ahead <= FIFO_NEAR_LIMIT) || (behind <= FIFO_NEAR_LIMIT);
	endfunction : fifo_near

	////////////////////////////////////////////////////////////////////////////////
	// Storage

	logic [7:0] code_reg [NUM_CH];
	logic [7:0] code_next [NUM_CH];
	logic [7:0] mask_reg [NUM_CH];
	logic [7:0] mask_next [NUM_CH];
	logic [7:0] status_reg [NUM_CH];
	logic [7:0] status_next [NUM_CH];
	logic [7:0] change_reg [NUM_CH];
	logic [7:0] change_next [NUM_CH];
	logic [NUM_CH-1:0] pending;

	logic gie_reg, gie_next;
	logic irq_reg, irq_next;

	bus_state_e bus_state_reg, bus_state_next;
	logic        wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0]  index;
	logic        do_write;
	logic        do_read;
	logic [7:0]  read_mux;
	logic [3:0]  ch_sel;

	assign index = address[9:2];
	assign ch_sel = index[7:4];

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave

	// Read multiplexer over global and channel registers, unmapped reads zero
	always_comb begin
		read_mux = 8'h00;
		if (index == REG_GLOBAL) begin
			read_mux[BIT_GLOBAL_IRQ_EN] = gie_reg;
		end else if (int'(ch_sel) < NUM_CH) begin
			unique case (index[3:0])
				REG_CODE_INSERT: begin
					read_mux = code_reg[ch_sel] & CODE_WRITE_MASK; // R5
				end
				REG_ALARM_MASK: begin
					read_mux = mask_reg[ch_sel];
				end
				REG_ALARM_STATUS: begin
					read_mux = status_reg[ch_sel];
				end
				REG_ALARM_CHANGE: begin
					read_mux = change_reg[ch_sel];
				end
				default: begin
					read_mux = 8'h00;
				end
			endcase
		end
	end

	// Handshake: one wait cycle, then the access completes
	always_comb begin
		bus_state_next = bus_state_reg;
		wait_next = wait_reg;
		rdata_next = rdata_reg;
		do_write = 1'b0;
		do_read = 1'b0;
		unique case (bus_state_reg)
			BUS_IDLE: begin
				if (read || write) begin
					bus_state_next = BUS_ANSWER;
					wait_next = 1'b0;
					rdata_next = read ? {24'h00_0000, read_mux} : READ_ZERO;
				end
			end
			BUS_ANSWER: begin
				bus_state_next = BUS_IDLE;
				wait_next = 1'b1;
				do_write = write & byteenable[0];
				do_read = read;
			end
		endcase
	end

	// Bus registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			bus_state_reg <= BUS_IDLE;
			wait_reg <= 1'b1;
			rdata_reg <= READ_ZERO;
		end else begin
			bus_state_reg <= bus_state_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	assign waitrequest = wait_reg;
	assign readdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Global enable and interrupt pin

	// Global enable register
	always_comb begin
		gie_next = gie_reg;
		if (do_write && index == REG_GLOBAL) begin
			gie_next = writedata[BIT_GLOBAL_IRQ_EN];
		end
	end

	// Interrupt needs the global enable and an enabled pending change
	always_comb begin
		irq_next = gie_reg & (|pending); // R8
	end

	// Interrupt registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gie_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			gie_reg <= gie_next;
			irq_reg <= irq_next;
		end
	end

	assign irq = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel registers and error inserters

	generate
		for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
			logic [7:0] live;
			logic [7:0] clear_bits;
			logic       fifo_close;

			assign fifo_close = fifo_near(fifo_read_ptr[ch*FIFO_PTR_W +: FIFO_PTR_W],
				fifo_write_ptr[ch*FIFO_PTR_W +: FIFO_PTR_W]); // R12

			// Live alarm conditions in mask layout
			always_comb begin
				live = 8'h00;
				live[ALARM_EQUALIZER] = equalizer_attenuation_flag[ch]; // R10
				live[ALARM_DRIVER] = driver_failure_flag[ch]; // R11
				live[ALARM_FIFO_LIMIT] = fifo_close; // R12
				live[ALARM_CODE_VIOL] = code_violation_flag[ch];
				live[ALARM_LOOP_CODE] = loop_code_detected[ch];
				live[ALARM_ALL_ONES] = all_ones_detected[ch];
				live[ALARM_SIGNAL_LOSS] = receive_signal_lost[ch];
				live[ALARM_RANDOM_DET] = random_pattern_detected[ch];
			end

			// Writable control and mask registers of this channel
			always_comb begin
				code_next[ch] = code_reg[ch];
				mask_next[ch] = mask_reg[ch];
				if (do_write && chan_hit(index, ch, REG_CODE_INSERT)) begin
					code_next[ch] = writedata[7:0] & CODE_WRITE_MASK; // R5
				end
				if (do_write && chan_hit(index, ch, REG_ALARM_MASK)) begin
					mask_next[ch] = writedata[7:0]; // R6
				end
			end

			// Status follows alarms, change bits set on any edge and clear on read
			always_comb begin
				clear_bits = 8'h00;
				if (do_read && chan_hit(index, ch, REG_ALARM_CHANGE)) begin
					clear_bits = rdata_reg[7:0]; // R13
				end
				if (do_write && chan_hit(index, ch, REG_ALARM_CHANGE)) begin
					clear_bits = clear_bits | writedata[7:0];
				end
				status_next[ch] = live; // R9
				change_next[ch] = (change_reg[ch] & ~clear_bits) | (live ^ status_reg[ch]); // R13
			end

			assign pending[ch] = |(change_reg[ch] & mask_reg[ch]); // R7

			// Channel registers
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					code_reg[ch] <= CODE_RESET;
					mask_reg[ch] <= MASK_RESET; // R7
					status_reg[ch] <= STATUS_RESET;
					change_reg[ch] <= CHANGE_RESET;
				end else begin
					code_reg[ch] <= code_next[ch];
					mask_reg[ch] <= mask_next[ch];
					status_reg[ch] <= status_next[ch];
					change_reg[ch] <= change_next[ch];
				end
			end

			// Independent error inserter for this channel
			liu_error_insert u_insert (
				.clock                    (clock),
				.arst_n                   (arst_n),
				.transmit_line_clock      (transmit_line_clock[ch]),
				.pattern_active           (pattern_active[ch]),
				.insert_bipolar_violation (code_reg[ch][BIT_INSERT_BPV]),
				.insert_single_bit_error  (code_reg[ch][BIT_INSERT_BER]),
				.pattern_bit              (tx_pattern_bit[ch]),
				.line_bit                 (tx_line_bit[ch]),
				.bipolar_violation        (tx_bipolar_violation[ch])
			); // R14
		end
	endgenerate

endmodule : liu_alarm_irq

`default_nettype wire

/* File: verification/liu_alarm_chk.sv */
// Port checker for the alarm, interrupt and error insertion block.
// Assumes it is bound into liu_alarm_irq and sees only its ports.
`default_nettype none

module liu_alarm_chk
	import liu_alarm_pkg::*;
(
	input wire logic              clock,
	input wire logic              arst_n,
	input wire logic [9:0]        address,
	input wire logic              read,
	input wire logic              write,
	input wire logic [31:0]       readdata,
	input wire logic              waitrequest,
	input wire logic              irq,
	input wire logic [NUM_CH-1:0] transmit_line_clock,
	input wire logic [NUM_CH-1:0] pattern_active,
	input wire logic [NUM_CH-1:0] tx_pattern_bit,
	input wire logic [NUM_CH-1:0] tx_line_bit,
	input wire logic [NUM_CH-1:0] tx_bipolar_violation
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       wrote_reg;
	logic       errd_reg;
	logic [1:0] t0_reg;
	logic [1:0] t1_reg;
	logic       up0;
	logic       up1;

	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	////////////////////////////////////////////////////////////
	// Transmit clock history, write seen, last bit errored
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			t0_reg <= 2'h0;
			t1_reg <= 2'h0;
			wrote_reg <= 1'b0;
			errd_reg <= 1'b0;
		end else begin
			t0_reg <= {t0_reg[0], transmit_line_clock[0]};
			t1_reg <= {t1_reg[0], transmit_line_clock[1]};
			wrote_reg <= wrote_reg | (write & ~waitrequest);
			if (up0) errd_reg <= tx_line_bit[0] != $past(tx_pattern_bit[0]);
		end
	end
	// A bit update is due one clock after a transmit clock rise
	assign up0 = t0_reg == 2'h1;
	assign up1 = t1_reg == 2'h1;

	////////////////////////////////////////////////////////////
	upd_time_a: assert property ($changed(tx_line_bit[0]) |-> up0)
		else $error("line bit moved off a transmit rise");
	chan_apart_a: assert property ($changed(tx_bipolar_violation[1]) |-> up1)
		else $error("channel one marker moved off its own rise");
	idle_pass_a: assert property (up0 && !$past(pattern_active[0])
		|-> tx_line_bit[0] == $past(tx_pattern_bit[0]) && !tx_bipolar_violation[0])
		else $error("error inserted while no pattern runs");
	bpv_single_a: assert property (up0 && tx_bipolar_violation[0] |-> !$past(tx_bipolar_violation[0]))
		else $error("violation marked on two bits in a row");
	err_single_a: assert property (up0 && tx_line_bit[0] != $past(tx_pattern_bit[0]) |-> !errd_reg)
		else $error("bit error on two bits in a row");
	irq_cause_a: assert property (irq |-> wrote_reg)
		else $error("interrupt with all masks at reset value");
	irq_drop_a: assert property ($fell(irq) |-> !$past(waitrequest, 2))
		else $error("interrupt fell without a finished access");
	pad_bit_a: assert property (read && !waitrequest && address[5:2] == 4'h3 |-> !readdata[0])
		else $error("unused code bit read as one");
endmodule : liu_alarm_chk

bind liu_alarm_irq liu_alarm_chk i_chk (.clock, .arst_n, .address, .read, .write, .readdata, .waitrequest,
	.irq, .transmit_line_clock, .pattern_active, .tx_pattern_bit, .tx_line_bit, .tx_bipolar_violation);

`default_nettype wire

/* File: verification/liu_line_src.sv */
// Line-side source: transmit clock and test pattern for every channel.
// Assumes the 20 MHz clock; one line bit lasts eight clocks, the pattern alternates bit by bit.
`default_nettype none

module liu_line_src
	import liu_alarm_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              arst_n,
	output logic      [NUM_CH-1:0] transmit_line_clock,
	output logic      [NUM_CH-1:0] tx_pattern_bit
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_reg;

	// Free-running divider; the pattern flips between transmit rises, so a stuck line shows
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) cnt_reg <= 4'h0;
		else cnt_reg <= cnt_reg + 4'h1;
	end
	assign transmit_line_clock = {NUM_CH{cnt_reg[2]}};
	assign tx_pattern_bit = {NUM_CH{cnt_reg[3]}};
endmodule : liu_line_src

`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the alarm, interrupt and error insertion block.
// Assumes the line source model and the bound port checker.
`default_nettype none

module testbench
	import liu_alarm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                         clock, arst_n, read, write, irq, waitrequest;
	logic [9:0]                   address;
	logic [31:0]                  writedata, readdata, rd;
	logic [3:0]                   byteenable;
	logic [NUM_CH-1:0]            tlc, pat, act, lbit, bpv;
	logic [NUM_CH-1:0]            al [7];
	logic [NUM_CH*FIFO_PTR_W-1:0] rdp, wrp;
	logic                         t_q = 1'b0, u_q = 1'b0, p_q = 1'b0;
	int                           fail_count = 0, checks_done = 0, nerr = 0, nbpv = 0;
	int                           pos [7] = '{7, 6, 4, 3, 2, 1, 0};

	liu_line_src i_src (.clock, .arst_n, .transmit_line_clock(tlc), .tx_pattern_bit(pat));
	liu_alarm_irq i_dut (.clock, .arst_n, .address, .read, .write, .writedata, .byteenable, .readdata,
		.waitrequest, .irq, .transmit_line_clock(tlc), .pattern_active(act), .tx_pattern_bit(pat),
		.tx_line_bit(lbit), .tx_bipolar_violation(bpv), .equalizer_attenuation_flag(al[0]),
		.driver_failure_flag(al[1]), .code_violation_flag(al[2]), .loop_code_detected(al[3]),
		.all_ones_detected(al[4]), .receive_signal_lost(al[5]), .random_pattern_detected(al[6]),
		.fifo_read_ptr(rdp), .fifo_write_ptr(wrp));

	////////////////////////////////////////////////////////////
	// Clock generator
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Counts errored bits and violation markers on channel zero, one clock after each transmit rise
	always @(posedge clock) begin
		if (u_q && lbit[0] != p_q) nerr++;
		if (u_q && bpv[0]) nbpv++;
		u_q = tlc[0] && !t_q;
		if (u_q) p_q = pat[0];
		t_q = tlc[0];
	end

	////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// One Avalon access, held until waitrequest is sampled low; only the watchdog ends a hang
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clock);
		address <= {idx, 2'b00};
		read <= !wr;
		write <= wr;
		writedata <= {24'h00_0000, d};
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic rchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h00);
		chk(name, rd, exp);
	endtask : rchk
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (5000) @(posedge clock);
		fail_count++;
		summarize();
	end
	// Test sequence
	initial begin
		arst_n = 1'b0; read = 1'b0; write = 1'b0; address = '0; writedata = '0; byteenable = 4'hF;
		act = '0; rdp = '0; wrp = {NUM_CH{6'h20}};
		foreach (al[i]) al[i] = '0;
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		rchk("mask reset", 8'h04, 32'h0000_0000);
		bus(1'b1, 8'h13, 8'hFF);
		rchk("code pad bit", 8'h13, 32'h0000_00FE);
		rchk("unmapped", 8'h07, 32'h0000_0000);
		$display("registers done");
		foreach (al[i]) begin
			al[i][3] <= 1'b1;
			@(posedge clock);
			rchk("status", 8'h35, 32'h1 << pos[i]);
			al[i][3] <= 1'b0;
		end
		wrp[18 +: 6] <= 6'h03;
		@(posedge clock);
		rchk("fifo near", 8'h35, 32'h0000_0020);
		wrp[18 +: 6] <= 6'h04;
		@(posedge clock);
		rchk("fifo far", 8'h35, 32'h0000_0000);
		$display("status done");
		bus(1'b1, 8'h34, 8'h80);
		repeat (2) @(posedge clock);
		chk("irq no global", irq, 32'h0);
		bus(1'b1, 8'hE0, 8'h01);
		repeat (2) @(posedge clock);
		chk("irq on", irq, 32'h1);
		rchk("change bits", 8'h36, 32'h0000_00FF);
		repeat (2) @(posedge clock);
		chk("irq read clear", irq, 32'h0);
		al[1][3] <= 1'b1;
		repeat (4) @(posedge clock);
		chk("irq masked", irq, 32'h0);
		bus(1'b1, 8'h34, 8'h40);
		repeat (2) @(posedge clock);
		chk("irq unmasked", irq, 32'h1);
		bus(1'b1, 8'h36, 8'hFF);
		repeat (2) @(posedge clock);
		chk("irq write clear", irq, 32'h0);
		rchk("other mask", 8'h44, 32'h0000_0000);
		byteenable <= 4'hE;
		bus(1'b1, 8'h44, 8'hFF);
		byteenable <= 4'hF;
		rchk("lane off write", 8'h44, 32'h0000_0000);
		$display("interrupt done");
		act[0] <= 1'b1;
		bus(1'b1, 8'h03, 8'h02);
		repeat (40) @(posedge clock);
		bus(1'b1, 8'h03, 8'h04);
		repeat (40) @(posedge clock);
		chk("bit errors", nerr, 1);
		chk("violations", nbpv, 1);
		act[0] <= 1'b0;
		bus(1'b1, 8'h03, 8'h00);
		repeat (20) @(posedge clock);
		bus(1'b1, 8'h03, 8'h06);
		repeat (40) @(posedge clock);
		chk("idle errors", nerr, 1);
		chk("idle violations", nbpv, 1);
		@(negedge clock);
		chk("other lines", lbit[NUM_CH-1:1] ^ {(NUM_CH-1){p_q}}, 32'h0);
		chk("other markers", bpv[NUM_CH-1:1], 32'h0);
		$display("insertion done");
		summarize();
	end
endmodule : testbench

`default_nettype wire
